//--- pci_cfg_regs.svh
`ifndef PCI_CFG_REGS_SVH
`define PCI_CFG_REGS_SVH

// byte offsets of the header registers
`define OFF_MAKER        8'h00
`define OFF_PRODUCT      8'h02
`define OFF_CMD          8'h04

// doubleword index width and indices
`define DW_W             6
`define DW_ID            6'h00
`define DW_CMD           6'h01

// command register fields
`define CMD_IO           0
`define CMD_MEM          1
`define CMD_MASTER       2
`define CMD_SCM          3
`define CMD_WIE          4
`define CMD_PAL          5
`define CMD_PAR          6
`define CMD_STEP         7
`define CMD_SERR         8
`define CMD_B2B          9
`define CMD_WR_MASK      16'h0357
`define CMD_RESET        16'h0000
`define STAT_DPE_BIT     15

// identity values, arbitrary
`define MAKER_ID         16'h5A3C
`define PRODUCT_LEGACY   16'h0E10
`define PRODUCT_ENH      16'h0E20

// functions
`define NUM_FUNC         3
`define FUNC_ENH         2'h2
`define FUNC_W           2

`endif

//--- pci_cfg_pkg.sv
package pci_cfg_pkg;

  typedef struct packed {
    logic        we;
    logic [1:0]  func;
    logic [5:0]  dw;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_access_t;

  typedef struct packed {
    logic io;
    logic mem;
    logic master;
    logic wie;
    logic par;
    logic serr;
    logic b2b;
  } cmd_ctrl_t;

  typedef enum logic [1:0] {
    SPACE_CFG,
    SPACE_MEM,
    SPACE_IO,
    SPACE_SPECIAL
  } tgt_space_t;

endpackage

//--- cmd_reg_bank.sv
`timescale 1ns/1ps
`include "pci_cfg_regs.svh"

module cmd_reg_bank (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     wr_en,
  input  wire logic [1:0]               be,
  input  wire logic [15:0]              wdata,
  output logic      [15:0]              cmd_q,
  output pci_cfg_pkg::cmd_ctrl_t        ctrl
);

  logic [15:0] cmd_d;
  logic [15:0] lane_mask;

  always_comb begin
    lane_mask = {{8{be[1]}}, {8{be[0]}}} & `CMD_WR_MASK;
    cmd_d     = cmd_q;
    if (wr_en) begin
      // read-only and reserved bits stay zero
      cmd_d = (cmd_q & ~lane_mask) | (wdata & lane_mask);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_q <= `CMD_RESET;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  always_comb begin
    ctrl.io     = cmd_q[`CMD_IO];
    ctrl.mem    = cmd_q[`CMD_MEM];
    ctrl.master = cmd_q[`CMD_MASTER];
    ctrl.wie    = cmd_q[`CMD_WIE];
    ctrl.par    = cmd_q[`CMD_PAR];
    ctrl.serr   = cmd_q[`CMD_SERR];
    ctrl.b2b    = cmd_q[`CMD_B2B];
  end

endmodule // cmd_reg_bank

//--- parity_report.sv
`timescale 1ns/1ps

module parity_report (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire pci_cfg_pkg::cmd_ctrl_t   ctrl,
  input  wire logic                     addr_perr,
  input  wire logic                     data_perr,
  input  wire logic                     dpe_clear,
  output logic                          serr_oe_q,
  output logic                          perr_oe_q,
  output logic                          dpe_q
);

  logic serr_oe_d;
  logic perr_oe_d;
  logic dpe_d;

  always_comb begin
    // system error only with both enables set
    serr_oe_d = addr_perr & ctrl.serr & ctrl.par;
    // no parity signalling while response is off
    perr_oe_d = data_perr & ctrl.par;
    dpe_d     = dpe_q;
    if (dpe_clear) begin
      dpe_d = 1'b0;
    end
    // a new error beats a clear in the same cycle
    if (addr_perr | data_perr) begin
      dpe_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      serr_oe_q <= 1'b0;
      perr_oe_q <= 1'b0;
      dpe_q     <= 1'b0;
    end else begin
      serr_oe_q <= serr_oe_d;
      perr_oe_q <= perr_oe_d;
      dpe_q     <= dpe_d;
    end
  end

endmodule // parity_report

//--- pci_config_header_ids_command.sv
`timescale 1ns/1ps
`include "pci_cfg_regs.svh"

module pci_config_header_ids_command #(
  // arbitrary identity values
  parameter logic [15:0] MAKER_ID       = `MAKER_ID,
  parameter logic [15:0] PRODUCT_LEGACY = `PRODUCT_LEGACY,
  parameter logic [15:0] PRODUCT_ENH    = `PRODUCT_ENH
) (
  input  wire logic                     clk,
  input  wire logic                     srst,
  // configuration access port
  input  wire logic                     cfg_valid,
  input  wire pci_cfg_pkg::cfg_access_t cfg_access,
  output logic                          cfg_ack_q,
  output logic [31:0]                   cfg_rdata_q,
  // target decode
  input  wire logic                     tgt_valid,
  input  wire logic [1:0]               tgt_func,
  input  wire pci_cfg_pkg::tgt_space_t  tgt_space,
  output logic                          tgt_claim_q,
  output logic                          tgt_ignore_q,
  // master side, per function
  input  wire logic [2:0]               mst_req,
  input  wire logic [2:0]               mst_back_to_back,
  input  wire logic [2:0]               mst_same_target,
  input  wire logic [2:0]               mst_want_wi,
  output logic [2:0]                    mst_grant_q,
  output logic [2:0]                    mst_use_wi_q,
  output logic [2:0]                    detached_q,
  // parity events, per function
  input  wire logic [2:0]               addr_perr,
  input  wire logic [2:0]               data_perr,
  input  wire logic [2:0]               dpe_clear,
  output logic [2:0]                    dpe_q,
  // open-drain error pins
  output logic                          serr_o_q,
  output logic                          serr_oe_q,
  output logic                          perr_o_q,
  output logic                          perr_oe_q
);

  logic [15:0]             cmd_q   [`NUM_FUNC];
  pci_cfg_pkg::cmd_ctrl_t  ctrl    [`NUM_FUNC];
  logic [2:0]              fn_serr;
  logic [2:0]              fn_perr;
  logic [2:0]              cmd_wr;

  // product word per function
  function automatic logic [15:0] product_of(input logic [1:0] f);
    product_of = (f == `FUNC_ENH) ? PRODUCT_ENH : PRODUCT_LEGACY;
  endfunction

  function automatic logic func_ok(input logic [1:0] f);
    func_ok = (f < `FUNC_W'(`NUM_FUNC));
  endfunction

  // per-function command register and parity reporting
  genvar g;
  generate
    for (g = 0; g < `NUM_FUNC; g = g + 1) begin : g_func
      assign cmd_wr[g] = cfg_valid & cfg_access.we
                         & (cfg_access.func == `FUNC_W'(g))
                         & (cfg_access.dw == `DW_CMD);

      cmd_reg_bank u_cmd (
        .clk   (clk),
        .srst  (srst),
        .wr_en (cmd_wr[g]),
        .be    (cfg_access.be[1:0]),
        .wdata (cfg_access.wdata[15:0]),
        .cmd_q (cmd_q[g]),
        .ctrl  (ctrl[g])
      );

      parity_report u_par (
        .clk       (clk),
        .srst      (srst),
        .ctrl      (ctrl[g]),
        .addr_perr (addr_perr[g]),
        .data_perr (data_perr[g]),
        .dpe_clear (dpe_clear[g]),
        .serr_oe_q (fn_serr[g]),
        .perr_oe_q (fn_perr[g]),
        .dpe_q     (dpe_q[g])
      );
    end
  endgenerate

  // configuration read answer
  logic        cfg_ack_d;
  logic [31:0] cfg_rdata_d;

  always_comb begin
    cfg_ack_d   = cfg_valid;
    cfg_rdata_d = 32'h0000_0000;
    if (cfg_valid && !cfg_access.we && func_ok(cfg_access.func)) begin
      unique case (cfg_access.dw)
        `DW_ID: begin
          // maker low, product high; writes never land here
          cfg_rdata_d = {product_of(cfg_access.func), MAKER_ID};
        end
        `DW_CMD: begin
          // status half out of this block, reads zero
          cfg_rdata_d = {16'h0000, cmd_q[cfg_access.func]};
        end
        default: begin
          cfg_rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_ack_q   <= 1'b0;
      cfg_rdata_q <= 32'h0000_0000;
    end else begin
      cfg_ack_q   <= cfg_ack_d;
      cfg_rdata_q <= cfg_rdata_d;
    end
  end

  // target claim
  logic tgt_claim_d;
  logic tgt_ignore_d;

  always_comb begin
    tgt_claim_d  = 1'b0;
    tgt_ignore_d = 1'b0;
    if (tgt_valid && func_ok(tgt_func)) begin
      unique case (tgt_space)
        pci_cfg_pkg::SPACE_CFG: begin
          // configuration always answered, even when detached
          tgt_claim_d = 1'b1;
        end
        pci_cfg_pkg::SPACE_MEM: begin
          tgt_claim_d = ctrl[tgt_func].mem;
        end
        pci_cfg_pkg::SPACE_IO: begin
          tgt_claim_d = ctrl[tgt_func].io;
        end
        pci_cfg_pkg::SPACE_SPECIAL: begin
          // special cycle monitoring is fixed off
          tgt_claim_d = 1'b0;
        end
      endcase
      tgt_ignore_d = ~tgt_claim_d;
    end else if (tgt_valid) begin
      tgt_ignore_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tgt_claim_q  <= 1'b0;
      tgt_ignore_q <= 1'b0;
    end else begin
      tgt_claim_q  <= tgt_claim_d;
      tgt_ignore_q <= tgt_ignore_d;
    end
  end

  // master gating and detach indication
  logic [2:0] mst_grant_d;
  logic [2:0] mst_use_wi_d;
  logic [2:0] detached_d;

  always_comb begin
    for (int f = 0; f < `NUM_FUNC; f++) begin
      // fast back-to-back to another target needs the enable
      mst_grant_d[f]  = mst_req[f] & ctrl[f].master
                        & (~mst_back_to_back[f] | mst_same_target[f]
                           | ctrl[f].b2b);
      mst_use_wi_d[f] = mst_req[f] & mst_want_wi[f]
                        & ctrl[f].master & ctrl[f].wie;
      detached_d[f]   = (cmd_q[f] == `CMD_RESET);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mst_grant_q  <= 3'h0;
      mst_use_wi_q <= 3'h0;
      detached_q   <= 3'h7;
    end else begin
      mst_grant_q  <= mst_grant_d;
      mst_use_wi_q <= mst_use_wi_d;
      detached_q   <= detached_d;
    end
  end

  // shared open-drain error pins, driven low when enabled
  logic serr_oe_d;
  logic perr_oe_d;

  always_comb begin
    serr_oe_d = |fn_serr;
    perr_oe_d = |fn_perr;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      serr_o_q  <= 1'b0;
      serr_oe_q <= 1'b0;
      perr_o_q  <= 1'b0;
      perr_oe_q <= 1'b0;
    end else begin
      serr_o_q  <= 1'b0;
      serr_oe_q <= serr_oe_d;
      perr_o_q  <= 1'b0;
      perr_oe_q <= perr_oe_d;
    end
  end

endmodule // pci_config_header_ids_command

//--- pci_cfg_checker_props.sv
`timescale 1ns/1ps
module pci_cfg_checker #(
  parameter logic [15:0] MAKER_ID       = 16'h0000,
  parameter logic [15:0] PRODUCT_LEGACY = 16'h0000,
  parameter logic [15:0] PRODUCT_ENH    = 16'h0000
) (
  input wire logic                     clk,
  input wire logic                     srst,
  input wire logic                     cfg_valid,
  input wire pci_cfg_pkg::cfg_access_t cfg_access,
  input wire logic                     cfg_ack_q,
  input wire logic [31:0]              cfg_rdata_q,
  input wire logic                     tgt_valid,
  input wire logic [1:0]               tgt_func,
  input wire pci_cfg_pkg::tgt_space_t  tgt_space,
  input wire logic                     tgt_claim_q,
  input wire logic                     tgt_ignore_q,
  input wire logic [2:0]               addr_perr,
  input wire logic                     serr_oe_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence rd_s(d);
    cfg_valid && !cfg_access.we && cfg_access.dw == d;
  endsequence
  a_ack_one_cycle: assert property (
    !$past(srst) |-> cfg_ack_q == $past(cfg_valid))
    else $error("ack not one cycle after request");
  a_legacy_id_word: assert property (
    rd_s(6'h00) ##0 cfg_access.func < 2'h2
      |=> cfg_rdata_q == {PRODUCT_LEGACY, MAKER_ID})
    else $error("legacy identity word wrong");
  a_enh_id_word: assert property (
    rd_s(6'h00) ##0 cfg_access.func == 2'h2
      |=> cfg_rdata_q == {PRODUCT_ENH, MAKER_ID})
    else $error("enhanced identity word wrong");
  a_absent_func_zero: assert property (
    rd_s(6'h00) ##0 cfg_access.func == 2'h3 |=> cfg_rdata_q == 32'h0)
    else $error("absent function read not zero");
  a_cmd_fixed_zero: assert property (
    rd_s(6'h01) |=> (cfg_rdata_q & 32'hFFFF_FCA8) == 32'h0)
    else $error("fixed command bits not zero");
  a_tgt_one_answer: assert property (
    tgt_valid |=> tgt_claim_q ^ tgt_ignore_q)
    else $error("decode answer not exactly one");
  a_cfg_claimed: assert property (
    tgt_valid && tgt_space == pci_cfg_pkg::SPACE_CFG && tgt_func != 2'h3
      |=> tgt_claim_q)
    else $error("configuration access not claimed");
  a_special_ignored: assert property (
    tgt_valid && tgt_space == pci_cfg_pkg::SPACE_SPECIAL |=> tgt_ignore_q)
    else $error("special cycle claimed");
  a_serr_cause: assert property (
    serr_oe_q |-> $past(addr_perr, 2) != 3'h0)
    else $error("system error driven without cause");
endmodule // pci_cfg_checker

bind pci_config_header_ids_command pci_cfg_checker #(
  .MAKER_ID(MAKER_ID), .PRODUCT_LEGACY(PRODUCT_LEGACY),
  .PRODUCT_ENH(PRODUCT_ENH)
) i_pci_cfg_checker (
  .clk, .srst, .cfg_valid, .cfg_access, .cfg_ack_q, .cfg_rdata_q, .tgt_valid,
  .tgt_func, .tgt_space, .tgt_claim_q, .tgt_ignore_q, .addr_perr, .serr_oe_q
);

//--- pci_host_bridge_model.sv
`timescale 1ns/1ps
module pci_host_bridge_model #(
  parameter bit ALL_FAST = 1'h1
) (
  input  wire logic                clk,
  input  wire logic                cfg_ack_q,
  input  wire logic [31:0]         cfg_rdata_q,
  output logic                     cfg_valid,
  output pci_cfg_pkg::cfg_access_t cfg_access
);
  initial begin
    cfg_valid = 1'h0;
    cfg_access = '0;
  end
  task automatic access(input logic we, input logic [1:0] func,
    input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wdata,
    input logic strict, output logic [31:0] rdata, output logic ok);
    logic [31:0] wd;
    wd = wdata;
    if (strict && dw == 6'h01) begin
      wd[15:10] = 6'h00;
      if (!ALL_FAST) wd[9] = 1'h0;
    end
    @(posedge clk);
    cfg_valid <= 1'h1;
    cfg_access <= '{we: we, func: func, dw: dw, be: be, wdata: wd};
    @(posedge clk);
    cfg_valid <= 1'h0;
    cfg_access.wdata <= ~wd; // released wdata lines carry the inverted write data; the other fields keep their values
    ok = 1'h0;
    rdata = '0;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      ok = (cfg_ack_q === 1'h1);
      rdata = cfg_rdata_q;
      if (!ok) @(posedge clk);
    end
  endtask
endmodule // pci_host_bridge_model

//--- pci_config_header_ids_command_tb.sv
`timescale 1ns/1ps
`include "pci_cfg_regs.svh"
module pci_config_header_ids_command_tb;
  typedef struct packed {
    logic we; logic [1:0] func; logic [5:0] dw; logic [3:0] be;
    logic [31:0] wdata; logic [31:0] exp;
  } row_t;
  localparam logic [31:0] LEG = {`PRODUCT_LEGACY, `MAKER_ID};
  localparam logic [31:0] ENH = {`PRODUCT_ENH, `MAKER_ID};
  localparam logic [31:0] ONES = 32'hFFFF_FFFF;
  row_t rows [14] = '{
    '{1'h0, 2'h0, 6'h00, 4'hF, 32'h0, LEG},
    '{1'h0, 2'h1, 6'h00, 4'hF, 32'h0, LEG},
    '{1'h0, 2'h2, 6'h00, 4'hF, 32'h0, ENH},
    '{1'h1, 2'h0, 6'h00, 4'hF, ONES, 32'h0},
    '{1'h0, 2'h0, 6'h00, 4'hF, 32'h0, LEG},
    '{1'h0, 2'h0, 6'h01, 4'hF, 32'h0, 32'h0},
    '{1'h1, 2'h0, 6'h01, 4'hF, ONES, 32'h0},
    '{1'h0, 2'h0, 6'h01, 4'hF, 32'h0, 32'h357},
    '{1'h1, 2'h1, 6'h01, 4'h1, ONES, 32'h0},
    '{1'h0, 2'h1, 6'h01, 4'hF, 32'h0, 32'h57},
    '{1'h1, 2'h1, 6'h01, 4'h2, ONES, 32'h0},
    '{1'h0, 2'h1, 6'h01, 4'hF, 32'h0, 32'h357},
    '{1'h0, 2'h3, 6'h00, 4'hF, 32'h0, 32'h0},
    '{1'h0, 2'h0, 6'h05, 4'hF, 32'h0, 32'h0}};
  logic clk, srst, cfg_valid, cfg_ack_q, tgt_valid, tgt_claim_q, tgt_ignore_q;
  logic serr_o_q, serr_oe_q, perr_o_q, perr_oe_q;
  logic [31:0]              cfg_rdata_q, rd;
  logic [1:0]               tgt_func;
  logic [2:0]               mst_req, mst_back_to_back, mst_same_target;
  logic [2:0]               mst_want_wi, mst_grant_q, mst_use_wi_q, detached_q;
  logic [2:0]               addr_perr, data_perr, dpe_clear, dpe_q;
  pci_cfg_pkg::cfg_access_t cfg_access;
  pci_cfg_pkg::tgt_space_t  tgt_space;
  int                       error_cnt = 0, compares = 0;
  pci_config_header_ids_command i_pci_config_header_ids_command (.clk, .srst,
    .cfg_valid, .cfg_access, .cfg_ack_q, .cfg_rdata_q, .tgt_valid, .tgt_func,
    .tgt_space, .tgt_claim_q, .tgt_ignore_q, .mst_req, .mst_back_to_back,
    .mst_same_target, .mst_want_wi, .mst_grant_q, .mst_use_wi_q, .detached_q,
    .addr_perr, .data_perr, .dpe_clear, .dpe_q, .serr_o_q, .serr_oe_q,
    .perr_o_q, .perr_oe_q);
  pci_host_bridge_model i_pci_host_bridge_model (.clk, .cfg_ack_q,
    .cfg_rdata_q, .cfg_valid, .cfg_access);
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cfg(input logic we, input logic [1:0] f, input logic [5:0] dw,
    input logic [3:0] be, input logic [31:0] wd, input logic strict);
    logic ok;
    i_pci_host_bridge_model.access(we, f, dw, be, wd, strict, rd, ok);
    check("cfg_ack_q", 32'(ok), 32'h1);
    if (!ok) end_sim();
  endtask
  task automatic tgt(input logic [1:0] f, input int s, input logic c);
    @(posedge clk);
    tgt_valid <= 1'h1;
    tgt_func <= f;
    tgt_space <= pci_cfg_pkg::tgt_space_t'(s);
    @(posedge clk);
    tgt_valid <= 1'h0;
    #1;
    check("tgt_claim_q", 32'(tgt_claim_q), 32'(c));
    check("tgt_ignore_q", 32'(tgt_ignore_q), 32'(!c));
  endtask
  task automatic mst(input logic [2:0] b2b, same, exp);
    @(posedge clk);
    mst_back_to_back <= b2b;
    mst_same_target <= same;
    @(posedge clk);
    #1;
    check("mst_grant_q", 32'(mst_grant_q), 32'(exp));
  endtask
  task automatic pulse(input logic [2:0] a, d, detected_parity_error, input logic serr, perr);
    @(posedge clk);
    addr_perr <= a;
    data_perr <= d;
    @(posedge clk);
    addr_perr <= 3'h0;
    data_perr <= 3'h0;
    #1;
    check("dpe_q", 32'(dpe_q), 32'(detected_parity_error));
    @(posedge clk);
    #1;
    check("serr_oe_q", 32'(serr_oe_q), 32'(serr));
    check("err_o_q", 32'({serr_o_q, perr_o_q}), 32'h0);
    if (d != 3'h0) check("perr_oe_q", 32'(perr_oe_q), 32'(perr));
  endtask
  initial begin
    srst = 1'h1;
    {tgt_valid, tgt_func, addr_perr, data_perr, dpe_clear} = '0;
    tgt_space = pci_cfg_pkg::SPACE_CFG;
    {mst_req, mst_back_to_back, mst_same_target, mst_want_wi} = '0;
    repeat (20) @(posedge clk);
    srst <= 1'h0;
    #1;
    check("detached_q", 32'(detached_q), 32'h7);
    foreach (rows[i]) begin
      cfg(rows[i].we, rows[i].func, rows[i].dw, rows[i].be, rows[i].wdata,
          1'h0);
      check("cfg_rdata_q", rd, rows[i].exp);
    end
    $display("test register rows done");
    for (int s = 0; s < 4; s++) begin
      tgt(2'h0, s, s != 3);
      tgt(2'h2, s, s == 0);
    end
    tgt(2'h3, 0, 1'h0);
    check("detached_q", 32'(detached_q), 32'h4);
    $display("test decode done");
    cfg(1'h1, 2'h1, 6'h01, 4'h3, 32'h0000_0004, 1'h1);
    @(posedge clk);
    mst_req <= 3'h7;
    mst_want_wi <= 3'h7;
    mst(3'h7, 3'h0, 3'h1);
    check("mst_use_wi_q", 32'(mst_use_wi_q), 32'h1);
    mst(3'h7, 3'h7, 3'h3);
    mst(3'h0, 3'h0, 3'h3);
    $display("test master done");
    pulse(3'h1, 3'h0, 3'h1, 1'h1, 1'h0);
    pulse(3'h2, 3'h0, 3'h3, 1'h0, 1'h0);
    cfg(1'h1, 2'h1, 6'h01, 4'h3, 32'h0000_0100, 1'h1);
    pulse(3'h2, 3'h0, 3'h3, 1'h0, 1'h0);
    pulse(3'h0, 3'h2, 3'h3, 1'h0, 1'h0);
    pulse(3'h0, 3'h1, 3'h3, 1'h0, 1'h1);
    pulse(3'h0, 3'h4, 3'h7, 1'h0, 1'h0);
    @(posedge clk);
    dpe_clear <= 3'h7;
    @(posedge clk);
    dpe_clear <= 3'h0;
    #1;
    check("dpe_q", 32'(dpe_q), 32'h0);
    // error and clear in one cycle: the error wins
    @(posedge clk);
    dpe_clear <= 3'h4;
    addr_perr <= 3'h4;
    @(posedge clk);
    dpe_clear <= 3'h0;
    addr_perr <= 3'h0;
    #1;
    check("dpe_q", 32'(dpe_q), 32'h4);
    $display("test parity done");
    @(posedge clk);
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    #1;
    check("detached_q", 32'(detached_q), 32'h7);
    cfg(1'h0, 2'h0, 6'h01, 4'hF, 32'h0, 1'h0);
    check("cfg_rdata_q", rd, 32'h0);
    $display("test reset done");
    end_sim();
  end
endmodule // pci_config_header_ids_command_tb
